/* inc/adc_link_pkg.sv */
// Purpose: Shared constants for the serial converter readout link
// Assumes: One system clock at 100 MHz on both ends
// Notes: Serial clock is made by the host by division of its own clock
package adc_link_pkg;
   localparam int RESULT_W = 13;
   localparam logic [12:0] CODE_MOST_NEG = 13'h1000;
   localparam logic [12:0] CODE_MOST_POS = 13'h0FFF;
   localparam logic [12:0] CODE_FIRST_POS = 13'h0001;
   localparam logic [4:0] CONV_BITS = 5'h0D;
   localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
   localparam logic [4:0] BIT_CNT_ONE = 5'h01;
   // Sample window of 1.5 link clocks: the first rising edge plus one whole clock
   localparam logic [1:0] ACQ_RISES = 2'h2;
   localparam logic [1:0] ACQ_ZERO = 2'h0;
   localparam logic [1:0] ACQ_ONE = 2'h1;
   // Host serial clock: 80 ns period from 10 ns system clock
   localparam int SYS_PERIOD_NS = 10;
   localparam int LINK_PERIOD_NS = 80;
   localparam int HALF_DIV = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam logic [3:0] HALF_DIV_CNT = 4'(HALF_DIV - 1);
   localparam logic [3:0] DIV_ZERO = 4'h0;
   // Full clock cycles the host sends: acquisition plus conversion
   localparam logic [4:0] HOST_CLOCKS = 5'h0F;
   localparam int FIFO_DEPTH = 8;
   localparam logic [12:0] RESULT_ZERO = 13'h0000;
endpackage

/* inc/adc_link_if.sv */
// Purpose: Three-wire link between the converter and its host
// Assumes: All wires are single-driver, no tristate needed
// Notes: Serial output is driven by the converter at all times
`timescale 1ns/10ps
interface adc_link_if;
   logic select_shutdown_n;
   logic sclk;
   logic sdo;
   modport converter (input select_shutdown_n, input sclk, output sdo);
   modport host (output select_shutdown_n, output sclk, input sdo);
endinterface

/* core/result_fifo.sv */
// Purpose: Small valid/ready FIFO for conversion results
// Assumes: Single clock
// Notes: Honest full and empty; write refused when full
`timescale 1ns/10ps
module result_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // Handshake terms
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   // Storage
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= AW'(wr_q + 1'b1);
         end
         if (pop)
         begin
            rd_q <= AW'(rd_q + 1'b1);
         end
         cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
   end
endmodule // result_fifo

/* core/adc_converter.sv */
// Purpose: Converter end: sample, successive approximation, serial shift out
// Assumes: Link pins are asynchronous; sampled with two flip-flops
// Notes: Input difference is given as a digital word standing in for the analog pair
`timescale 1ns/10ps
// Functional notes
// R1: Select low starts a session
// R2: Select high aborts, enters standby
// R3: Host raises select after every conversion
// R4: Output changes only on falling clock edges
// R5: Host supplies the only conversion clock
// R6: Acquisition lasts one and a half clocks
// R7: Thirteen clocks convert, one bit each
// R8: Sign bit shifted out first
// R9: Result is 13-bit two's complement difference
// R10: Bipolar uses all 8192 codes
// R11: Codes 0x1000 lowest, 0x0FFF highest, 0x0001 first positive
// R12: Both inputs sampled together, then held
// R13: Host may slow clock for high impedance
// R14: Sign zero when positive input higher
// R15: Host keeps clock at least 85 kHz
// R16: Host captures on following rising edge
module adc_converter (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Analog stand-in: signed difference, clipped to code range
   input wire logic signed [13:0] diff_i,
   // Status
   output logic busy_o,
   // Link
   adc_link_if.converter link
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_CONV = 4'b0100,
      ST_DONE = 4'b1000
   } conv_state_t;

   conv_state_t state_q;
   logic cs_m_q, cs_s_q, clk_m_q, clk_s_q, clk_d1_q;
   logic rise, fall;
   logic [1:0] acq_q;
   logic [4:0] bit_q;
   logic [12:0] hold_q;
   logic [12:0] code;
   logic sdo_q;

   // Two-stage synchronisers for pins
   // Both link pins come from the host's clock domain; nothing but the second
   // stage is read, and the serial clock gets a third stage for edge detection
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         clk_m_q <= 1'b0;
         clk_s_q <= 1'b0;
         clk_d1_q <= 1'b0;
      end
      else
      begin
         cs_m_q <= link.select_shutdown_n;
         cs_s_q <= cs_m_q;
         clk_m_q <= link.sclk;
         clk_s_q <= clk_m_q;
         clk_d1_q <= clk_s_q;
      end
   end

   // Edge detection on the synchronised serial clock
   // Stages reset to the idle low level of the pin, so no false edge follows reset
   // and a clock left low between sessions is never mistaken for activity
   assign rise = clk_s_q && !clk_d1_q; // [R5]
   assign fall = !clk_s_q && clk_d1_q;

   // Clip the difference to the 13-bit two's complement range
   // Out-of-range inputs saturate at the end codes rather than wrapping
   always_comb
   begin
      if (diff_i > 14'sh0FFF)
      begin
         code = adc_link_pkg::CODE_MOST_POS; // [R11]
      end
      else if (diff_i < -14'sh1000)
      begin
         code = adc_link_pkg::CODE_MOST_NEG; // [R11] [R10]
      end
      else
      begin
         code = diff_i[12:0]; // [R9] [R14]
      end
   end

   // Session sequencing
   // A high select overrides everything and returns to standby at once. After the
   // last bit the block waits in ST_DONE for select to go high, so a select held
   // low can never start a second conversion; the host must raise it between
   // conversions.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_q <= ST_IDLE;
         acq_q <= adc_link_pkg::ACQ_ZERO;
         bit_q <= adc_link_pkg::BIT_CNT_ZERO;
      end
      else if (cs_s_q)
      begin
         state_q <= ST_IDLE; // [R2]
         acq_q <= adc_link_pkg::ACQ_ZERO;
         bit_q <= adc_link_pkg::BIT_CNT_ZERO;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               // Select seen low: acquisition starts on this session's first rising edge
               state_q <= ST_ACQ; // [R1]
               acq_q <= adc_link_pkg::ACQ_ZERO;
            end
            ST_ACQ:
            begin
               // Acquisition: first rising edge, one more clock, ends on a falling edge
               if (rise && acq_q != adc_link_pkg::ACQ_RISES)
               begin
                  acq_q <= 2'(acq_q + adc_link_pkg::ACQ_ONE);
               end
               if (fall && acq_q == adc_link_pkg::ACQ_RISES)
               begin
                  state_q <= ST_CONV; // [R6] [R12]
                  bit_q <= adc_link_pkg::BIT_CNT_ONE;
               end
            end
            ST_CONV:
            begin
               // Each falling edge completes one bit; the thirteenth ends the word
               if (fall)
               begin
                  if (bit_q == adc_link_pkg::CONV_BITS)
                  begin
                     state_q <= ST_DONE; // [R7]
                  end
                  else
                  begin
                     bit_q <= 5'(bit_q + adc_link_pkg::BIT_CNT_ONE);
                  end
               end
            end
            ST_DONE:
            begin
               // Word complete: hold until select is raised
               state_q <= ST_DONE;
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Hold both inputs together at the end of acquisition
   // The word is taken once, on the falling edge that ends acquisition; later
   // changes on the input cannot reach a conversion in progress, which is what
   // the held charge gives the analog part
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         hold_q <= adc_link_pkg::RESULT_ZERO;
      end
      else if (!cs_s_q && state_q == ST_ACQ && fall && acq_q == adc_link_pkg::ACQ_RISES)
      begin
         hold_q <= code; // [R12]
      end
      else if (!cs_s_q && state_q == ST_CONV && fall)
      begin
         hold_q <= {hold_q[11:0], 1'b0}; // Shift next bit up
      end
   end

   // Serial output changes only on falling edges
   // The new bit reaches the pin three system clocks after the host's falling
   // edge (two synchroniser stages and this register); the host must allow for
   // that before it samples. Standby drives the pin low.
   // No bit is shifted on the thirteenth falling edge: the last bit stays put.
   always_ff @(posedge clk_i)
   begin
      if (reset_i || cs_s_q)
      begin
         sdo_q <= 1'b0;
      end
      else if (state_q == ST_ACQ && fall && acq_q == adc_link_pkg::ACQ_RISES)
      begin
         sdo_q <= code[12]; // [R4] [R8]
      end
      else if (state_q == ST_CONV && fall && bit_q != adc_link_pkg::CONV_BITS)
      begin
         sdo_q <= hold_q[11]; // [R4]
      end
   end

   // Pin and status outputs; busy covers acquisition, conversion and the wait for select
   assign link.sdo = sdo_q;
   assign busy_o = (state_q != ST_IDLE);
endmodule // adc_converter

/* core/adc_host.sv */
// Purpose: Host end: drives select and serial clock, gathers 13 bits
// Assumes: Single system clock; serial clock made by divider
// Notes: Results pass through an 8-word FIFO; a full FIFO stalls new sessions
`timescale 1ns/10ps
module adc_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Request
   input wire logic start_i,
   output logic start_ready_o,
   // Result stream
   output logic result_valid_o,
   input wire logic result_ready_i,
   output logic [12:0] result_o,
   // Link
   adc_link_if.host link
);
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_RUN = 3'b010,
      HS_DONE = 3'b100
   } host_state_t;

   host_state_t state_q;
   logic [3:0] div_q;
   logic sclk_q;
   logic cs_n_q;
   logic [4:0] clocks_q;
   logic [12:0] shift_q;
   logic sdo_m_q, sdo_s_q;
   logic half_tick;
   logic fifo_ready;
   logic push_q;
   logic [1:0] take_q;

   // Sample the returned serial data with two flip-flops
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sdo_m_q <= 1'b0;
         sdo_s_q <= 1'b0;
      end
      else
      begin
         sdo_m_q <= link.sdo;
         sdo_s_q <= sdo_m_q;
      end
   end

   // Capture pipe: a bit set on a falling edge reaches sdo_s_q five system clocks
   // later, one clock after our next rising edge, so the rising edge that should
   // take it is marked here and the shift happens two clocks after it
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         take_q <= '0;
      end
      else
      begin
         take_q <= {take_q[0], (state_q == HS_RUN) && half_tick && !sclk_q &&
            (clocks_q >= 5'(adc_link_pkg::ACQ_RISES))}; // [R16]
      end
   end

   // Divider for half periods of the serial clock
   assign half_tick = (div_q == adc_link_pkg::HALF_DIV_CNT);
   always_ff @(posedge clk_i)
   begin
      if (reset_i || state_q != HS_RUN)
      begin
         div_q <= adc_link_pkg::DIV_ZERO;
      end
      else
      begin
         div_q <= half_tick ? adc_link_pkg::DIV_ZERO : 4'(div_q + 1'b1);
      end
   end

   // A result still on its way into the buffer counts as taken room, so the
   // last free word is never promised twice
   assign start_ready_o = (state_q == HS_IDLE) && fifo_ready && !push_q;

   // Session control: select low, clocks, select high again
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_q <= HS_IDLE;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         clocks_q <= adc_link_pkg::BIT_CNT_ZERO;
         shift_q <= adc_link_pkg::RESULT_ZERO;
         push_q <= 1'b0;
      end
      else
      begin
         push_q <= 1'b0;
         if (take_q[1])
         begin
            shift_q <= {shift_q[11:0], sdo_s_q}; // [R16] [R8]
         end
         unique case (state_q)
            HS_IDLE:
            begin
               if (start_i && start_ready_o)
               begin
                  cs_n_q <= 1'b0; // [R1]
                  state_q <= HS_RUN;
                  clocks_q <= adc_link_pkg::BIT_CNT_ZERO;
               end
            end
            HS_RUN:
            begin
               if (half_tick)
               begin
                  sclk_q <= !sclk_q; // [R5]
                  if (!sclk_q)
                  begin
                     // Rising edge: count it; the bit itself is taken by the capture pipe
                     clocks_q <= 5'(clocks_q + adc_link_pkg::BIT_CNT_ONE); // [R7]
                  end
                  else if (clocks_q == adc_link_pkg::HOST_CLOCKS)
                  begin
                     state_q <= HS_DONE;
                  end
               end
            end
            HS_DONE:
            begin
               cs_n_q <= 1'b1; // [R3]
               push_q <= 1'b1;
               state_q <= HS_IDLE;
            end
            default:
            begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   assign link.select_shutdown_n = cs_n_q;
   assign link.sclk = sclk_q;

   result_fifo #(
      .WIDTH(adc_link_pkg::RESULT_W),
      .DEPTH(adc_link_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(push_q),
      .in_ready_o(fifo_ready),
      .in_data_i(shift_q),
      .out_valid_o(result_valid_o),
      .out_ready_i(result_ready_i),
      .out_data_o(result_o)
   );
endmodule // adc_host

/* dv/adc_link_asserts.sv */
// Purpose: Wire checks on the converter link
// Assumes: Host makes the link clock from its own clock
// Notes: Watches the link between the two design ends only
`timescale 1ns/10ps
module adc_link_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Link wires
   input wire logic select_shutdown_n,
   input wire logic sclk,
   input wire logic sdo
);
   logic [4:0] rises_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Counts link clock rises within one session
   always_ff @(posedge clk_i)
   begin
      if (reset_i || select_shutdown_n)
         rises_q <= 5'h00;
      else if ($rose(sclk))
         rises_q <= rises_q + 5'h01;
   end
   property p_sdo_on_fall;
      !select_shutdown_n && !$past(select_shutdown_n) && !$stable(sdo) |-> !sclk;
   endproperty
   a_sdo_on_fall: assert property (p_sdo_on_fall)
      else $error("data changed while link clock high");
   property p_sel_gap;
      $rose(select_shutdown_n) |=> select_shutdown_n;
   endproperty
   a_sel_gap: assert property (p_sel_gap)
      else $error("select not held high between sessions");
   property p_sclk_idle;
      select_shutdown_n |-> !sclk;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("link clock moving outside a session");
   property p_sel_lead;
      $fell(select_shutdown_n) |-> !sclk [*3];
   endproperty
   a_sel_lead: assert property (p_sel_lead)
      else $error("link clock started with select");
   property p_sclk_half;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_sclk_half: assert property (p_sclk_half)
      else $error("link clock high phase wrong");
   property p_sclk_low;
      $fell(sclk) && rises_q != adc_link_pkg::HOST_CLOCKS |-> !sclk [*4] ##1 sclk;
   endproperty
   a_sclk_low: assert property (p_sclk_low)
      else $error("link clock low phase wrong");
   property p_clocks_per_session;
      $rose(select_shutdown_n) |-> rises_q == 5'h0F;
   endproperty
   a_clocks_per_session: assert property (p_clocks_per_session)
      else $error("session clock count wrong");
   property p_session_len;
      $fell(select_shutdown_n) |-> ##[100:160] select_shutdown_n;
   endproperty
   a_session_len: assert property (p_session_len)
      else $error("session did not end in time");
   property p_acq_quiet;
      !select_shutdown_n && rises_q == 5'h01 |-> $stable(sdo);
   endproperty
   a_acq_quiet: assert property (p_acq_quiet)
      else $error("data moved during acquisition");
endmodule // adc_link_asserts

/* dv/test_diff_sar_adc_serial_readout.sv */
// Purpose: Bench for converter and host ends joined by the link
// Assumes: Second link is driven by the bench to abort a session
// Notes: Row table covers code ends and clipping
`timescale 1ns/10ps
module test_diff_sar_adc_serial_readout;
   typedef struct {logic signed [13:0] diff; logic [12:0] code;} row_t;
   row_t rows [7] = '{'{14'sh0000, 13'h0000}, '{14'sh0001, adc_link_pkg::CODE_FIRST_POS},
      '{14'sh3FFF, 13'h1FFF}, '{14'sh0FFF, adc_link_pkg::CODE_MOST_POS},
      '{14'sh3000, adc_link_pkg::CODE_MOST_NEG}, '{14'sh1FFF, adc_link_pkg::CODE_MOST_POS},
      '{14'sh2000, adc_link_pkg::CODE_MOST_NEG}};
   logic clk_i, reset_i, start_q, ready_q, sel2_q, sclk2_q, busy_o, busy2_o, start_ready_o, result_valid_o;
   logic signed [13:0] diff_q;
   logic [12:0] result_o, wire_q, r;
   int bad_count, compares, cycles;
   adc_link_if link();
   adc_link_if link2();
   assign link2.select_shutdown_n = sel2_q;
   assign link2.sclk = sclk2_q;
   adc_converter u_adc_converter (.clk_i(clk_i), .reset_i(reset_i), .diff_i(diff_q), .busy_o(busy_o), .link(link));
   adc_host u_adc_host (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_q), .start_ready_o(start_ready_o),
      .result_valid_o(result_valid_o), .result_ready_i(ready_q), .result_o(result_o), .link(link));
   adc_converter u_adc_converter_abort (.clk_i(clk_i), .reset_i(reset_i), .diff_i(diff_q), .busy_o(busy2_o),
      .link(link2));
   adc_link_asserts u_adc_link_asserts (.clk_i(clk_i), .reset_i(reset_i),
      .select_shutdown_n(link.select_shutdown_n), .sclk(link.sclk), .sdo(link.sdo));
   // Clock and hang limit
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   // Host side capture of the wire
   always @(posedge link.sclk) wire_q <= {wire_q[11:0], link.sdo};
   task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Waits for the host to be free, then requests one session
   task automatic convert(input logic signed [13:0] d);
      do @(negedge clk_i); while (start_ready_o !== 1'b1);
      @(posedge clk_i);
      diff_q <= d;
      start_q <= 1'b1;
      @(posedge clk_i);
      start_q <= 1'b0;
   endtask
   task automatic wait_pop(output logic [12:0] v);
      int n;
      n = 0;
      @(negedge clk_i);
      while (result_valid_o !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      check("valid", {12'h000, result_valid_o}, 13'h0001);
      v = result_o;
      @(posedge clk_i);
      ready_q <= 1'b1;
      @(posedge clk_i);
      ready_q <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      clk_i = 0;
      reset_i = 1;
      {start_q, ready_q, sclk2_q} = 3'h0;
      sel2_q = 1;
      diff_q = 0;
      {bad_count, compares, cycles} = 0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      check("select in reset", {12'h000, link.select_shutdown_n}, 13'h0001);
      check("valid in reset", {12'h000, result_valid_o}, 13'h0000);
      @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (rows[i])
      begin
         convert(rows[i].diff);
         repeat (8) @(negedge clk_i);
         check("busy", {12'h000, busy_o}, 13'h0001);
         wait_pop(r);
         check("result", r, rows[i].code);
         check("wire word", wire_q, rows[i].code);
         check("sign", {12'h000, r[12]}, {12'h000, rows[i].diff < 0});
      end
      // Back to back sessions until the buffer refuses
      for (int k = 0; k < 8; k++)
         convert(14'(5 + k));
      repeat (140) @(negedge clk_i);
      check("ready when full", {12'h000, start_ready_o}, 13'h0000);
      for (int k = 0; k < 8; k++)
      begin
         wait_pop(r);
         check("queued", r, 13'(5 + k));
      end
      // Abort a session on the bench driven link
      @(posedge clk_i);
      sel2_q <= 1'b0;
      repeat (3)
      begin
         repeat (4) @(posedge clk_i);
         sclk2_q <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk2_q <= 1'b0;
      end
      @(negedge clk_i);
      check("busy in session", {12'h000, busy2_o}, 13'h0001);
      @(posedge clk_i);
      sel2_q <= 1'b1;
      repeat (6) @(negedge clk_i);
      check("busy after abort", {12'h000, busy2_o}, 13'h0000);
      check("busy idle", {12'h000, busy_o}, 13'h0000);
      wrap_up();
   end
endmodule // test_diff_sar_adc_serial_readout
